// ==== rtl/efb_dev.sv ====
// device end: strap decode, register writes, fifo allocation, dma select
module efb_dev (
  input  wire logic        CLOCK_IN,          // 20 MHz system clock
  input  wire logic        RSTN_IN,           // async reset, active low
  efb_if.dev               link,              // microcontroller side
  input  wire logic        USB_RESET_IN,      // one-cycle usb bus reset
  input  wire logic [15:0] FIFO_DATA_IN,      // per slot valid data present
  input  wire logic [3:0]  QUERY_EP_IN,       // slot for max packet query
  output logic [1:0]       MODE_OUT,          // decoded bus mode
  output logic             MODE_BAD_OUT,      // reserved strap code
  output logic             PIO_WIDE_OUT,      // pio uses all 16 lines
  output logic [1:0]       DMA_LANE_OUT,      // dma lane code
  output logic             DMA_ACTIVE_OUT,    // dma path enabled and legal
  output logic [3:0]       DMA_EP_OUT,        // endpoint number on dma
  output logic             DMA_DIR_OUT,       // 1 transmit (write), 0 read
  output logic [15:0]      EP_ALLOC_OUT,      // slots holding storage
  output logic [15:0]      EP_DIR_OUT,        // per slot direction
  output logic [15:0]      RATE_FB_OUT,       // slots in rate-feedback mode
  output logic [12:0]      USED_BYTES_OUT,    // physical bytes in use
  output logic [10:0]      MAX_PKT_OUT,       // logical size of query slot
  output logic             SEQ_ERR_OUT,       // slots written out of order
  output logic             LOST_OUT           // fifo contents undefined
);
  // logical size of a slot from its code and iso bit
  function automatic logic [10:0] lsize(input logic [3:0] c,
                                        input logic       iso);
    if (iso)
      lsize = efb_pkg::ISO_SIZES[c];
    else
      lsize = efb_pkg::NONISO_BASE << c[1:0];
  endfunction

  // code is legal for its kind; rate feedback only on transmit slots
  function automatic logic code_ok(input logic [7:0] e);
    code_ok = e[efb_pkg::ECR_ISO_BIT]
      || (e[3:2] == 2'b00)
      || ((e[3:2] == 2'b10) && e[efb_pkg::ECR_DIR_BIT]);
  endfunction

  logic [7:0]  ecr_q [efb_pkg::NUM_EP];   // endpoint config slots
  logic [7:0]  dcr_q;                     // dma config
  logic [7:0]  sel_q;                     // register selected by command
  logic        addr_q;                    // latched address bit
  logic        ale_q;                     // ale one cycle ago
  logic        strap_done_q;              // straps captured
  logic [1:0]  mode_q;
  logic [3:0]  next_q;                    // slot expected next
  logic [15:0] alloc_q;
  logic [12:0] used_q;
  logic        done_q;
  logic        err_q;
  logic        seq_err_q;
  logic        lost_q;
  logic        dma_act_q;
  logic [1:0]  lane_q;
  logic [3:0]  dma_ep_q;
  logic        dma_dir_q;
  logic [10:0] max_q;
  logic [15:0] dir_q;
  logic [15:0] rfb_q;

  // decode of the bus side
  wire ale_fall  = ale_q && !link.ale;
  wire mode_bad  = (mode_q == efb_pkg::MODE_RSV);
  wire wr_ok     = link.wr && strap_done_q && !mode_bad;
  wire cmd_wr    = wr_ok && addr_q;
  wire dat_wr    = wr_ok && !addr_q;
  wire ecr_wr    = dat_wr && (sel_q <= efb_pkg::SEL_ECR_LAST);
  wire dcr_wr    = dat_wr && (sel_q == efb_pkg::SEL_DMA_CFG);
  wire [3:0] slot = sel_q[3:0];
  wire apply     = ecr_wr && (sel_q == efb_pkg::SEL_ECR_LAST);
  wire any_rst   = USB_RESET_IN;

  // allocation walk over the configurable slots, in slot order
  logic [15:0] alloc_d;
  logic [12:0] used_d;
  logic [12:0] nis_d;
  logic        err_d;
  always_comb
  begin
    logic [7:0]  e;
    logic [12:0] phys;
    logic        dbl;
    e       = 8'h00;
    phys    = 13'h0000;
    dbl     = 1'b0;
    alloc_d = 16'h0003;
    used_d  = efb_pkg::CTRL_BYTES << 1;
    nis_d   = 13'h0000;
    err_d   = 1'b0;
    for (int i = efb_pkg::FIRST_CFG; i < efb_pkg::NUM_EP; i++)
    begin
      // the slot being written now counts with its new value
      e = (ecr_wr && (slot == i[3:0])) ? link.data[7:0] : ecr_q[i];
      // codes with bit 3 set (rate feedback) are single; iso and the rest are double
      dbl  = e[efb_pkg::ECR_ISO_BIT] || !e[3];
      phys = {2'b00, lsize(e[3:0], e[efb_pkg::ECR_ISO_BIT])} << dbl;
      if (!e[efb_pkg::ECR_EN_BIT])
      begin
        // disabled slot keeps zero bytes
      end
      else if (!code_ok(e)
               || (used_d + phys > efb_pkg::TOTAL_BYTES)
               || (!e[efb_pkg::ECR_ISO_BIT]
                   && (nis_d + phys > efb_pkg::NONISO_BYTES)))
        err_d = 1'b1;
      else
      begin
        alloc_d[i] = 1'b1;
        used_d     = used_d + phys;
        if (!e[efb_pkg::ECR_ISO_BIT])
          nis_d = nis_d + phys;
      end
    end
  end

  // dma selection from the dma config register
  wire [3:0] d_idx   = dcr_q[efb_pkg::DCR_IDX_LSB +: 4];
  wire       d_wide  = dcr_q[efb_pkg::DCR_WD_BIT];
  wire       d_cfg   = d_idx >= 4'(efb_pkg::FIRST_CFG);
  wire       d_legal = !((mode_q == efb_pkg::MODE_1) && d_wide);
  wire       d_act   = dcr_q[efb_pkg::DCR_EN_BIT] && d_cfg
                       && alloc_q[d_idx] && d_legal && !mode_bad;
  wire [1:0] d_lane  = (mode_q == efb_pkg::MODE_1) ? efb_pkg::LANE_HI
                     : d_wide ? efb_pkg::LANE_ALL
                     : efb_pkg::LANE_LO;
  // max packet of the queried slot, zero when it holds no storage
  wire [10:0] q_size = (QUERY_EP_IN < 4'(efb_pkg::FIRST_CFG))
                     ? efb_pkg::CTRL_BYTES[10:0]
                     : lsize(ecr_q[QUERY_EP_IN][3:0],
                             ecr_q[QUERY_EP_IN][efb_pkg::ECR_ISO_BIT]);
  // data present in any allocated slot while the allocation map changes
  wire change_hit = |(FIFO_DATA_IN & alloc_q) && (alloc_d != alloc_q);

  // strap capture after release; mode then holds until the next RSTN_IN low
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      strap_done_q <= 1'b0;
      mode_q       <= efb_pkg::MODE_0;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      mode_q       <= link.bus_cfg_straps;
    end
  end

  // address phase: ale low edge latches pin 0 as command/data flag
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      ale_q  <= 1'b0;
      addr_q <= 1'b0;
      sel_q  <= 8'h00;
    end
    else
    begin
      ale_q <= link.ale;
      if (ale_fall)
        addr_q <= link.addr_data_pin0;
      if (cmd_wr)
        sel_q <= link.data[7:0];
    end
  end

  // config slots; control slots are fixed and never written
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      for (int i = 0; i < efb_pkg::NUM_EP; i++)
        ecr_q[i] <= efb_pkg::ECR_RST;
      dcr_q <= efb_pkg::DCR_RST;
    end
    else if (any_rst)
    begin
      for (int i = 0; i < efb_pkg::NUM_EP; i++)
        ecr_q[i] <= efb_pkg::ECR_RST;
      dcr_q <= efb_pkg::DCR_RST;
    end
    else
    begin
      if (ecr_wr && (slot >= 4'(efb_pkg::FIRST_CFG)))
        ecr_q[slot] <= link.data[7:0];
      if (dcr_wr)
        dcr_q <= link.data[7:0];
    end
  end

  // allocation applied when the last slot lands
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      alloc_q   <= 16'h0003;
      used_q    <= efb_pkg::CTRL_BYTES << 1;
      next_q    <= 4'h0;
      done_q    <= 1'b0;
      err_q     <= 1'b0;
      seq_err_q <= 1'b0;
      lost_q    <= 1'b0;
    end
    else if (any_rst)
    begin
      alloc_q   <= 16'h0003;
      used_q    <= efb_pkg::CTRL_BYTES << 1;
      next_q    <= 4'h0;
      done_q    <= 1'b0;
      err_q     <= 1'b0;
      seq_err_q <= 1'b0;
      lost_q    <= 1'b0;
    end
    else
    begin
      done_q <= apply;
      if (ecr_wr)
      begin
        // out-of-order slot write is flagged, sequence resyncs
        if (slot != next_q)
          seq_err_q <= 1'b1;
        next_q <= apply ? 4'h0 : slot + 4'h1;
      end
      if (apply)
      begin
        alloc_q <= alloc_d;
        used_q  <= used_d;
        err_q   <= err_d;
        // contents cannot be trusted; sticky until a reset
        if (change_hit)
          lost_q <= 1'b1;
      end
    end
  end

  // registered outputs derived from mode, slots and dma config
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      dma_act_q <= 1'b0;
      lane_q    <= efb_pkg::LANE_LO;
      dma_ep_q  <= 4'h0;
      dma_dir_q <= 1'b0;
      max_q     <= 11'h000;
      dir_q     <= 16'h0002;
      rfb_q     <= 16'h0000;
    end
    else
    begin
      dma_act_q <= d_act;
      lane_q    <= d_lane;
      dma_ep_q  <= d_idx - 4'h1;
      dma_dir_q <= ecr_q[d_idx][efb_pkg::ECR_DIR_BIT];
      max_q     <= alloc_q[QUERY_EP_IN] ? q_size : 11'h000;
      for (int i = 0; i < efb_pkg::NUM_EP; i++)
      begin
        dir_q[i] <= (i < efb_pkg::FIRST_CFG) ? (i == 1)
                  : ecr_q[i][efb_pkg::ECR_DIR_BIT];
        rfb_q[i] <= alloc_q[i] && !ecr_q[i][efb_pkg::ECR_ISO_BIT]
                  && (ecr_q[i][3:2] == 2'b10);
      end
    end
  end

  // outputs from flops, mode flags gated by strap capture
  assign MODE_OUT       = mode_q;
  assign MODE_BAD_OUT   = strap_done_q && mode_bad;
  assign PIO_WIDE_OUT   = strap_done_q && (mode_q == efb_pkg::MODE_0);
  assign DMA_LANE_OUT   = lane_q;
  assign DMA_ACTIVE_OUT = dma_act_q;
  assign DMA_EP_OUT     = dma_ep_q;
  assign DMA_DIR_OUT    = dma_dir_q;
  assign EP_ALLOC_OUT   = alloc_q;
  assign EP_DIR_OUT     = dir_q;
  assign RATE_FB_OUT    = rfb_q;
  assign USED_BYTES_OUT = used_q;
  assign MAX_PKT_OUT    = max_q;
  assign SEQ_ERR_OUT    = seq_err_q;
  assign LOST_OUT       = lost_q;
  assign link.cfg_done  = done_q;
  assign link.cfg_err   = err_q;
endmodule

// ==== pkg/efb_pkg.sv ====
// shared constants for the endpoint fifo and bus configuration block
package efb_pkg;
  // endpoint counts
  localparam int NUM_EP    = 16;                // config slots, 0 and 1 fixed
  localparam int FIRST_CFG = 2;                 // first configurable slot
  // bus configuration modes from the straps
  localparam logic [1:0] MODE_0   = 2'h0;       // 16-bit pio, shared dma
  localparam logic [1:0] MODE_1   = 2'h1;       // 8-bit pio, separate dma
  localparam logic [1:0] MODE_2   = 2'h2;       // 8-bit pio, shared dma
  localparam logic [1:0] MODE_RSV = 2'h3;       // reserved
  // dma lane codes
  localparam logic [1:0] LANE_LO  = 2'h0;       // low data byte
  localparam logic [1:0] LANE_HI  = 2'h1;       // high data byte
  localparam logic [1:0] LANE_ALL = 2'h2;       // all sixteen lines
  // endpoint config register fields
  localparam int ECR_SZ_LSB  = 0;               // fifo_size_code [3:0]
  localparam int ECR_ISO_BIT = 4;               // iso_select_bit
  localparam int ECR_DIR_BIT = 5;               // ep_direction_bit
  localparam int ECR_EN_BIT  = 6;               // ep_fifo_enable
  localparam logic [7:0] ECR_RST = 8'h00;       // value after any reset
  // dma config register fields
  localparam int DCR_IDX_LSB = 0;               // dma_ep_index [3:0]
  localparam int DCR_EN_BIT  = 4;               // dma_enable_bit
  localparam int DCR_WD_BIT  = 5;               // dma_width_sel
  localparam logic [7:0] DCR_RST = 8'h00;
  // register selectors sent in the command byte
  localparam logic [7:0] SEL_ECR_LAST = 8'h0F;  // slot 15
  localparam logic [7:0] SEL_DMA_CFG  = 8'h10;
  // storage figures in bytes
  localparam logic [12:0] CTRL_BYTES   = 13'h0040;   // 64 per control fifo
  localparam logic [12:0] TOTAL_BYTES  = 13'h099E;   // 2462
  localparam logic [12:0] NONISO_BYTES = 13'h0200;   // 512
  localparam logic [10:0] NONISO_BASE  = 11'h008;    // 8 bytes at code 0
  // isochronous logical sizes, index is the size code
  localparam logic [15:0][10:0] ISO_SIZES = {
    11'h3FF, 11'h380, 11'h300, 11'h280, 11'h200, 11'h180, 11'h140, 11'h100,
    11'h0C0, 11'h0A0, 11'h080, 11'h060, 11'h040, 11'h030, 11'h020, 11'h010};
  // host sequencer states
  typedef enum logic [4:0] {
    EFB_IDLE  = 5'b00001,
    EFB_ADDR  = 5'b00010,
    EFB_LATCH = 5'b00100,
    EFB_WRITE = 5'b01000,
    EFB_DONE  = 5'b10000
  } efb_state_t;
endpackage

// ==== pkg/efb_if.sv ====
// link between the microcontroller and the endpoint configuration logic
interface efb_if;
  logic [1:0]  bus_cfg_straps;   // board straps, host side drives
  logic        ale;              // address latch enable, falling edge latches
  logic        addr_data_pin0;   // address bit during ale, held until the next address phase
  logic        wr;               // one-cycle write strobe
  logic [15:0] data;             // write data, low byte used for registers
  logic        cfg_done;         // pulse after slot 15 is applied
  logic        cfg_err;          // level, configuration not fully served
  modport dev (input bus_cfg_straps, ale, addr_data_pin0, wr, data,
               output cfg_done, cfg_err);
  modport host (output bus_cfg_straps, ale, addr_data_pin0, wr, data,
                input cfg_done, cfg_err);
endinterface

// ==== rtl/efb_host.sv ====
// host end: straps and the ordered configuration write sequence
module efb_host #(
  parameter logic [1:0] STRAPS = 2'h0        // board strap setting
) (
  input  wire logic        CLOCK_IN,          // 20 MHz system clock
  input  wire logic        RSTN_IN,           // async reset, active low
  efb_if.host              link,              // device side
  input  wire logic        START_IN,          // pulse, begin a sequence
  input  wire logic        FIFO_BUSY_IN,      // some enabled fifo has data
  input  wire logic [7:0]  ECR_VAL_IN,        // value for ECR_IDX_OUT
  input  wire logic [7:0]  DMA_CFG_IN,        // dma config value
  output logic [3:0]       ECR_IDX_OUT,       // slot being sent
  output logic             BUSY_OUT,          // sequence running
  output logic             DONE_OUT,          // pulse, sequence finished
  output logic             REFUSED_OUT,       // pulse, start refused
  output logic             ERR_OUT            // device reported bad config
);
  // reserved strap code cannot be served; refused at elaboration
  if (STRAPS == efb_pkg::MODE_RSV)
  begin : g_strap_chk
    $error("reserved strap setting");
  end

  efb_pkg::efb_state_t state_q;
  logic [4:0]  item_q;      // 0..15 slots, 16 dma config
  logic        phase_q;     // 1 command byte, 0 data byte
  logic        ale_q;
  logic        ad0_q;
  logic        wr_q;
  logic [15:0] data_q;
  logic        done_q;
  logic        ref_q;
  logic        err_q;

  // wide dma is illegal in mode 1, so strip it there
  wire [7:0] dma_val = (STRAPS == efb_pkg::MODE_1)
      ? (DMA_CFG_IN & ~(8'h01 << efb_pkg::DCR_WD_BIT)) : DMA_CFG_IN;
  wire       is_dma  = item_q[4];
  wire [7:0] sel_val = is_dma ? efb_pkg::SEL_DMA_CFG : {3'b000, item_q};
  wire [7:0] dat_val = is_dma ? dma_val : ECR_VAL_IN;
  wire [7:0] byte_v  = phase_q ? sel_val : dat_val;

  // sequencer: address phase, latch, write strobe, per byte
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      state_q <= efb_pkg::EFB_IDLE;
      item_q  <= 5'h00;
      phase_q <= 1'b1;
      ale_q   <= 1'b0;
      ad0_q   <= 1'b0;
      wr_q    <= 1'b0;
      data_q  <= 16'h0000;
      done_q  <= 1'b0;
      ref_q   <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      ref_q  <= 1'b0;
      wr_q   <= 1'b0;
      case (state_q)
        efb_pkg::EFB_IDLE:
        begin
          // never move storage while data sits in a fifo
          if (START_IN && FIFO_BUSY_IN)
            ref_q <= 1'b1;
          else if (START_IN)
          begin
            item_q  <= 5'h00;
            phase_q <= 1'b1;
            state_q <= efb_pkg::EFB_ADDR;
          end
        end
        efb_pkg::EFB_ADDR:
        begin
          ale_q   <= 1'b1;
          ad0_q   <= phase_q;
          state_q <= efb_pkg::EFB_LATCH;
        end
        efb_pkg::EFB_LATCH:
        begin
          ale_q   <= 1'b0;
          state_q <= efb_pkg::EFB_WRITE;
        end
        efb_pkg::EFB_WRITE:
        begin
          wr_q    <= 1'b1;
          data_q  <= {8'h00, byte_v};
          phase_q <= !phase_q;
          // every slot in order, then the dma config
          if (!phase_q && is_dma)
            state_q <= efb_pkg::EFB_DONE;
          else
          begin
            if (!phase_q)
              item_q <= item_q + 5'h01;
            state_q <= efb_pkg::EFB_ADDR;
          end
        end
        efb_pkg::EFB_DONE:
        begin
          done_q  <= 1'b1;
          state_q <= efb_pkg::EFB_IDLE;
        end
        default:
          state_q <= efb_pkg::EFB_IDLE;
      endcase
    end
  end

  // device flags an illegal size code or an allocation beyond its storage
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      err_q <= 1'b0;
    else
      err_q <= link.cfg_err;
  end

  assign link.bus_cfg_straps = STRAPS;
  assign link.ale            = ale_q;
  assign link.addr_data_pin0 = ad0_q;
  assign link.wr             = wr_q;
  assign link.data           = data_q;
  assign ECR_IDX_OUT         = item_q[3:0];
  assign BUSY_OUT            = (state_q != efb_pkg::EFB_IDLE);
  assign DONE_OUT            = done_q;
  assign REFUSED_OUT         = ref_q;
  assign ERR_OUT             = err_q;
endmodule

// ==== test/efb_props.sv ====
// link assertions for the endpoint configuration pair
module efb_props (
  input wire logic        CLOCK_IN,       // system clock
  input wire logic        RSTN_IN,        // async reset, active low
  input wire logic [1:0]  bus_cfg_straps, // board straps
  input wire logic        ale,            // address latch enable
  input wire logic        addr_data_pin0, // muxed address bit
  input wire logic        wr,             // write strobe
  input wire logic [15:0] data,           // write data
  input wire logic        cfg_done,       // apply pulse
  input wire logic        cfg_err         // refused slot flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);
  AST_STRAP_HOLD: assert property ($stable(bus_cfg_straps))
    else $error("straps moved");
  AST_ALE_ONE: assert property (ale |=> !ale)
    else $error("ale too long");
  AST_LATCH_WR: assert property ($fell(ale) |=> wr)
    else $error("no write after latch");
  AST_WR_GAP: assert property (wr |=> !wr [*2])
    else $error("writes too close");
  AST_WR_LOW: assert property (wr |-> !ale && data[15:8] == 8'h00)
    else $error("bad write byte");
  AST_DONE_ONE: assert property (cfg_done |=> !cfg_done)
    else $error("done too long");
  AST_DONE_WR: assert property (cfg_done |-> $past(wr))
    else $error("done without write");
  AST_ERR_APPLY: assert property ($rose(cfg_err) |-> cfg_done)
    else $error("error outside apply");
  AST_PAIR: assert property ($fell(ale) && $past(addr_data_pin0) |->
    ##3 ($fell(ale) && !$past(addr_data_pin0)))
    else $error("command not paired");
  // main scenarios seen
  cover property (cfg_done && cfg_err);
  cover property (cfg_done && !cfg_err);
  cover property ($fell(ale) && $past(addr_data_pin0));
endmodule

// ==== test/tb_endpoint_fifo_bus_config.sv ====
// self-checking bench joining host and device ends
module tb_endpoint_fifo_bus_config;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] alloc; // slots holding storage
    logic [12:0] used;  // physical bytes
    logic [15:0] rfb;   // rate-feedback slots
    logic        err;   // refused slot
    logic        lost;  // contents undefined
    logic        act;   // dma path live
    logic [10:0] pkt;   // query slot size
    logic [15:0] dir;   // per slot direction
  } efb_exp_t;
  logic        clk = 1'b0;               // 20 MHz
  logic        rstn = 1'b0;              // active low
  logic        usb_rst = 1'b0;           // bus reset pulse
  logic        start = 1'b0;             // sequence start
  logic        busy = 1'b0;              // fifo holds data
  logic [15:0] fdata = 16'h0000;         // per slot data
  logic [3:0]  query = 4'h0;             // size query slot
  logic [7:0]  ecr_val = 8'h00;          // slot value to host
  logic [7:0]  dma_cfg = 8'h00;          // dma config value
  logic [7:0]  ep_config_reg [16];                 // planned slot values
  logic [15:0] prev = 16'h0003;          // alloc before apply
  logic [31:0] rnd = 32'h00013E86;       // lfsr state
  logic [1:0]  mode, lane;               // bus mode, dma lane
  logic        wide, act, seq, lost, done, refused, err;
  logic        ddir, mbad;               // dma direction, reserved mode
  logic [15:0] ep_direction_bit;                    // per slot direction map
  logic [3:0]  dma_ep, idx;              // dma endpoint, host slot
  logic [15:0] alloc, rfb;               // alloc and feedback maps
  logic [12:0] used;                     // bytes in use
  logic [10:0] pkt;                      // queried size
  efb_exp_t    q [$];                    // expected results
  efb_exp_t    got;                      // note taken off
  int          fail_count = 0;
  int          num_checks = 0;
  efb_if link ();
  efb_dev i_efb_dev (.CLOCK_IN(clk), .RSTN_IN(rstn), .link(link),
    .USB_RESET_IN(usb_rst), .FIFO_DATA_IN(fdata), .QUERY_EP_IN(query),
    .MODE_OUT(mode), .MODE_BAD_OUT(mbad), .PIO_WIDE_OUT(wide),
    .DMA_LANE_OUT(lane), .DMA_ACTIVE_OUT(act), .DMA_EP_OUT(dma_ep),
    .DMA_DIR_OUT(ddir), .EP_ALLOC_OUT(alloc), .EP_DIR_OUT(ep_direction_bit),
    .RATE_FB_OUT(rfb), .USED_BYTES_OUT(used), .MAX_PKT_OUT(pkt),
    .SEQ_ERR_OUT(seq), .LOST_OUT(lost));
  efb_host #(.STRAPS(efb_pkg::MODE_0)) i_efb_host (.CLOCK_IN(clk),
    .RSTN_IN(rstn), .link(link), .START_IN(start), .FIFO_BUSY_IN(busy),
    .ECR_VAL_IN(ecr_val), .DMA_CFG_IN(dma_cfg), .ECR_IDX_OUT(idx),
    .BUSY_OUT(), .DONE_OUT(done), .REFUSED_OUT(refused), .ERR_OUT(err));
  efb_props i_efb_props (.CLOCK_IN(clk), .RSTN_IN(rstn),
    .bus_cfg_straps(link.bus_cfg_straps), .ale(link.ale),
    .addr_data_pin0(link.addr_data_pin0), .wr(link.wr),
    .data(link.data), .cfg_done(link.cfg_done), .cfg_err(link.cfg_err));
  always #25 clk = ~clk;
  // host asks for slot idx; one cycle of lag is absorbed by the address and latch cycles
  always @(posedge clk)
    ecr_val <= ep_config_reg[idx];
  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // expected allocation, worked out slot by slot in index order
  function automatic efb_exp_t model();
    efb_exp_t    e;
    logic [12:0] p, non;
    logic        rf;
    e = '0;
    e.alloc = 16'h0003;
    e.used = 13'(2 * efb_pkg::CTRL_BYTES);
    e.dir = 16'h0002;                 // control in transmits
    non = 13'h0000;
    for (int s = efb_pkg::FIRST_CFG; s < efb_pkg::NUM_EP; s++)
    begin
      p = 13'h0000;
      rf = !ep_config_reg[s][4] && ep_config_reg[s][3:2] == 2'h2 && ep_config_reg[s][5];
      e.dir[s] = ep_config_reg[s][5];
      if (ep_config_reg[s][4])
        p = {1'b0, efb_pkg::ISO_SIZES[ep_config_reg[s][3:0]], 1'b0};
      else if (ep_config_reg[s][3:2] == 2'h0)
        p = 13'h0010 << ep_config_reg[s][1:0];  // doubled
      else if (rf)
        p = 13'h0008 << ep_config_reg[s][1:0];
      if (ep_config_reg[s][6] && (p == 13'h0000 || e.used + p > efb_pkg::TOTAL_BYTES
          || (!ep_config_reg[s][4] && non + p > efb_pkg::NONISO_BYTES)))
        e.err = 1'b1;
      else if (ep_config_reg[s][6])
      begin
        e.alloc[s] = 1'b1;
        e.used = e.used + p;
        e.rfb[s] = rf;
        non = ep_config_reg[s][4] ? non : non + p;
        if (s == query)
          e.pkt = rf ? p[10:0] : p[11:1];
      end
    end
    e.act = dma_cfg[4] && dma_cfg[3:0] >= 4'h2 && e.alloc[dma_cfg[3:0]];
    e.lost = (e.alloc != prev) && |(fdata & prev);
    return e;
  endfunction
  // note the outcome, start the host, wait for its finish
  task automatic run_cfg();
    int n;
    got = model();
    q.push_back(got);
    prev = got.alloc;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 300 && done !== 1'b1; n++)
      @(posedge clk);
    if (n == 300)
    begin
      fail_count++;                   // hang counts as a mismatch
      summarize();
    end
    repeat (6) @(posedge clk);
  endtask
  // results follow the done pulse by up to one cycle
  always @(posedge clk)
  begin
    if (done === 1'b1)
    begin
      repeat (3) @(posedge clk);
      got = q.pop_front();
      chk("alloc", alloc, got.alloc);
      chk("used", 16'(used), 16'(got.used));
      chk("ratefb", rfb, got.rfb);
      chk("err", 16'(err), 16'(got.err));
      chk("lost", 16'(lost), 16'(got.lost));
      chk("dma", 16'(act), 16'(got.act));
      chk("dmaep", 16'(dma_ep), 16'(dma_cfg[3:0] - 4'h1));
      chk("lane", 16'(lane), dma_cfg[5] ? 16'(efb_pkg::LANE_ALL)
          : 16'(efb_pkg::LANE_LO));
      chk("pkt", 16'(pkt), 16'(got.pkt));
      chk("order", 16'(seq), 16'h0000);
      chk("ep_direction_bit", ep_direction_bit, got.dir);
      chk("dmadir", 16'(ddir), 16'(ep_config_reg[dma_cfg[3:0]][5]));
    end
  end
  // reset, two applies with a refusal between, then bus reset
  initial
  begin
    foreach (ep_config_reg[i])
    begin
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      ep_config_reg[i] = rnd[7:0] & 8'hBF;      // random but disabled
    end
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("mode", 16'(mode), 16'(efb_pkg::MODE_0));
    chk("wide", 16'(wide), 16'h0001);
    chk("modebad", 16'(mbad), 16'h0000);
    chk("alloc0", alloc, 16'h0003);
    chk("used0", 16'(used), 16'h0080);
    {ep_config_reg[2], ep_config_reg[3], ep_config_reg[4], ep_config_reg[5], ep_config_reg[6]} = 40'h7F41684403;
    dma_cfg <= 8'h32;
    query <= 4'h2;
    fdata <= rnd[15:0] & 16'hFFFC;
    @(posedge clk);
    run_cfg();
    busy <= 1'b1;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    chk("refused", 16'(refused), 16'h0001);
    busy <= 1'b0;
    ep_config_reg[3] = 8'h5F;
    dma_cfg <= 8'h13;
    query <= 4'h3;
    fdata <= 16'h0008;
    @(posedge clk);
    run_cfg();
    usb_rst <= 1'b1;
    @(posedge clk);
    usb_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("allocr", alloc, 16'h0003);
    chk("lostr", 16'(lost), 16'h0000);
    summarize();
  end
endmodule
